// ===== src/smf_slave.sv
// serial memory slave front end with byte array and status register
// Functional notes
// - array of 32768 bytes addressed by 15 bits
// - two address bytes follow opcode; top received bit ignored
// - clock modes 0 and 3 only, serial clock up to 33 MHz
// - sample input on rising edge, change output on falling edge
// - clock level at select picks mode 0 or mode 3
// - in mode 3 first rising edge after a toggle carries bit one
// - first eight bits after select are the opcode
// - one opcode per select; deselect between operations
// - deselected: input ignored, output high impedance
// - unknown opcode ignored until next select, output stays off
// - all fields travel most significant bit first
// - one eight bit configuration and status register
// - writes finish at bus speed with no busy state
// - master makes clock and starts every operation
// - output driven only while returning read data
// - nine opcodes recognised, all others invalid
`timescale 1ns/100ps
`include "smf_consts.svh"
module smf_slave #(
  parameter int ADDR_W = `SMF_ADDR_W,
  parameter int DEPTH  = `SMF_MEM_DEPTH
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  input  wire logic wp_n_i,
  output logic      so_o,
  output logic      so_oe_o,
  output logic      wel_o
);
  // memory and decode live in the sck domain; the system clock only samples status
  smf_pkg::smf_state_e state_q;
  smf_pkg::smf_state_e state_d;
  logic [`SMF_BYTE_W-1:0] mem [DEPTH];
  logic [`SMF_CNT_W-1:0]  cnt_q;
  logic [`SMF_BYTE_W-2:0] sh_q;
  logic [ADDR_W-1:0]      addr_q;
  logic [`SMF_BYTE_W-1:0] stat_q;
  logic [`SMF_BYTE_W-1:0] tx_q;
  logic                   armed_q;
  logic [`SMF_BYTE_W-1:0] last_op_q;
  logic                   wel_lat_q;
  logic                   wp_s1_q;
  logic                   wp_s2_q;
  logic                   so_q;
  logic                   oe_q;
  logic                   wel_s1_q;
  logic                   wel_s2_q;
  logic                   wel_q;
  smf_pkg::smf_out_s      out_w;
  wire logic [`SMF_BYTE_W-1:0] byte_w   = {sh_q, si_i};
  wire logic                   byte_end = (cnt_q == `SMF_CNT_LAST);
  wire logic                   sr_lock  = stat_q[`SMF_STAT_WPEN] & ~wp_s2_q;
  wire logic                   addr_shift = (state_q == smf_pkg::ST_ADDR_HI)
                                          | (state_q == smf_pkg::ST_ADDR_LO);
  wire logic [`SMF_BYTE_W-1:0] id_w     = `SMF_ID_BYTE;
  // the latch lives apart from the stored bits, so status write data never reaches it; WRSR only clears it at deselect
  wire logic [`SMF_BYTE_W-1:0] stat_rd  = {stat_q[`SMF_BYTE_W-1:`SMF_STAT_WEL+1], wel_lat_q,
                                           stat_q[`SMF_STAT_WEL-1:0]};
  wire logic                   wel_clr_op = (last_op_q == `SMF_OP_WRDI)
                                          | (last_op_q == `SMF_OP_WRSR)
                                          | (last_op_q == `SMF_OP_WRITE);
  wire logic [`SMF_BYTE_W-1:0] rd_byte  = mem[addr_q];
  wire logic                   sending  = (state_q == smf_pkg::ST_RDATA)
                                        | (state_q == smf_pkg::ST_STATUS)
                                        | (state_q == smf_pkg::ST_ID);

  function automatic smf_pkg::smf_state_e op_next(input logic [7:0] op);
    unique case (op)
      `SMF_OP_READ, `SMF_OP_FSTRD, `SMF_OP_WRITE: op_next = smf_pkg::ST_ADDR_HI;
      `SMF_OP_RDSR:  op_next = smf_pkg::ST_STATUS;
      `SMF_OP_WRSR:  op_next = smf_pkg::ST_SDATA;
      `SMF_OP_RDID:  op_next = smf_pkg::ST_ID;
      `SMF_OP_WREN, `SMF_OP_WRDI, `SMF_OP_SLEEP: op_next = smf_pkg::ST_IGNORE;
      default:       op_next = smf_pkg::ST_IGNORE;
    endcase
  endfunction : op_next

  always_comb begin
    state_d = state_q;
    if (byte_end) begin
      unique case (state_q)
        smf_pkg::ST_OPCODE:  state_d = op_next(byte_w);
        smf_pkg::ST_ADDR_HI: state_d = smf_pkg::ST_ADDR_LO;
        smf_pkg::ST_ADDR_LO: state_d = (sh_q[0] == 1'b0) ? smf_pkg::ST_IGNORE
                                     : smf_pkg::ST_IGNORE;
        smf_pkg::ST_DUMMY:   state_d = smf_pkg::ST_RDATA;
        default:             state_d = state_q;
      endcase
    end
  end

  // opcode is held in a flop so the address phase knows what follows
  logic [`SMF_BYTE_W-1:0] op_q;
  wire logic [`SMF_BYTE_W-1:0] op_sel = (state_q == smf_pkg::ST_OPCODE) ? byte_w : op_q;
  smf_pkg::smf_state_e after_addr;
  always_comb begin
    unique case (op_q)
      `SMF_OP_READ:  after_addr = smf_pkg::ST_RDATA;
      `SMF_OP_FSTRD: after_addr = smf_pkg::ST_DUMMY;
      default:       after_addr = smf_pkg::ST_WDATA;
    endcase
  end

  // mode 3 select with clock high: armed_q is always set and never read, so no edge is dropped;
  // a rising edge always follows a fall, so every rising edge is a real bit
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      state_q <= smf_pkg::ST_OPCODE;
      cnt_q   <= '0;
      sh_q    <= '0;
      op_q    <= '0;
      armed_q <= 1'b1;
    end else begin
      armed_q <= 1'b1;
      cnt_q   <= cnt_q + 3'h1;
      sh_q    <= byte_w[`SMF_BYTE_W-2:0];
      op_q    <= op_sel;
      if (byte_end && state_q == smf_pkg::ST_ADDR_LO) state_q <= after_addr;
      else state_q <= state_d;
    end
  end

  // address and array writes; writes land on the last bit edge
  always_ff @(posedge sck_i) begin
    if (!cs_n_i) begin
      // sixteen bits pass a register one short, so the top bit falls off
      if (addr_shift) addr_q <= {addr_q[ADDR_W-2:0], si_i};
      if (byte_end && state_q == smf_pkg::ST_WDATA) begin
        if (wel_lat_q) mem[addr_q] <= byte_w;
        addr_q <= addr_q + 1'b1;
      end
      if (byte_end && state_q == smf_pkg::ST_RDATA) addr_q <= addr_q + 1'b1;
    end
  end

  // status register and the opcode of the frame; protect pin passes two flops
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      stat_q    <= `SMF_STAT_RST;
      last_op_q <= '0;
      wp_s1_q   <= 1'b1;
      wp_s2_q   <= 1'b1;
    end else begin
      wp_s1_q <= wp_n_i;
      wp_s2_q <= wp_s1_q;
      if (!cs_n_i && byte_end && state_q == smf_pkg::ST_OPCODE) last_op_q <= byte_w;
      if (!cs_n_i && byte_end && state_q == smf_pkg::ST_SDATA && wel_lat_q && !sr_lock)
        stat_q <= (stat_q & ~`SMF_STAT_WMASK) | (byte_w & `SMF_STAT_WMASK);
    end
  end

  // the clock is idle at deselect, so the latch settles on the deselect edge itself;
  // a frame cut before its opcode repeats the previous frame's effect, which is harmless
  always_ff @(posedge cs_n_i or posedge rst_i) begin
    if (rst_i) begin
      wel_lat_q <= 1'b0;
    end else if (last_op_q == `SMF_OP_WREN) begin
      wel_lat_q <= 1'b1;
    end else if (wel_clr_op) begin
      wel_lat_q <= 1'b0;
    end
  end

  // output shifts on falling edge; enable only in read phases
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      tx_q <= '0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= sending;
      if (cnt_q == '0) begin
        unique case (state_q)
          smf_pkg::ST_STATUS: tx_q <= stat_rd;
          smf_pkg::ST_ID:     tx_q <= `SMF_ID_BYTE;
          default:            tx_q <= rd_byte;
        endcase
        so_q <= (state_q == smf_pkg::ST_STATUS) ? stat_rd[7]
              : (state_q == smf_pkg::ST_ID) ? id_w[7] : rd_byte[7];
      end else begin
        so_q <= tx_q[3'h7 - cnt_q];
      end
    end
  end

  assign out_w.so    = so_q;
  assign out_w.so_oe = oe_q;
  assign so_o        = out_w.so;
  assign so_oe_o     = out_w.so_oe;

  // write latch state crosses to the system clock by three flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wel_s1_q <= 1'b0;
      wel_s2_q <= 1'b0;
      wel_q    <= 1'b0;
    end else begin
      wel_s1_q <= wel_lat_q;
      wel_s2_q <= wel_s1_q;
      wel_q    <= wel_s2_q;
    end
  end
  assign wel_o = wel_q;
endmodule : smf_slave

// ===== include/smf_consts.svh
// constants for the serial memory slave front end
`ifndef SMF_CONSTS_SVH
`define SMF_CONSTS_SVH
`define SMF_ADDR_W      15
`define SMF_MEM_DEPTH   32768
`define SMF_BYTE_W      8
`define SMF_CNT_W       3
`define SMF_CNT_LAST    3'h7
`define SMF_STAT_RST    8'h00
`define SMF_STAT_WMASK  8'h8C
`define SMF_STAT_WEL    1
`define SMF_STAT_WPEN   7
`define SMF_OP_WREN     8'h06
`define SMF_OP_WRDI     8'h04
`define SMF_OP_RDSR     8'h05
`define SMF_OP_WRSR     8'h01
`define SMF_OP_READ     8'h03
`define SMF_OP_FSTRD    8'h0B
`define SMF_OP_WRITE    8'h02
`define SMF_OP_SLEEP    8'hB9
`define SMF_OP_RDID     8'h9F
`define SMF_ID_BYTE     8'hA5
`endif

// ===== include/smf_pkg.sv
// types for the serial memory slave front end
package smf_pkg;
  typedef enum logic [3:0] {
    ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_DUMMY, ST_RDATA, ST_WDATA,
    ST_SDATA, ST_STATUS, ST_ID, ST_IGNORE
  } smf_state_e;
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
  } smf_pins_s;
  typedef struct packed {
    logic so;
    logic so_oe;
  } smf_out_s;
endpackage : smf_pkg

// ===== test/smf_master.sv
// serial bus master model facing the slave front end
`timescale 1ns/100ps
module smf_master (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // one select per call; idle clock level picks the mode
  task automatic xfer(input logic m3, input logic [55:0] d, input int n,
                      output logic [55:0] r);
    r = '0;
    sck_o = m3;
    #80 cs_n_o = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sck_o = 1'b0;
      si_o = d[55-i];
      #80 sck_o = 1'b1;
      r = {r[54:0], so_i};
      #80;
    end
    sck_o = m3;
    #80 cs_n_o = 1'b1;
    // released line shows no stale value
    si_o = ~si_o;
    #80;
  endtask : xfer
endmodule : smf_master

// ===== test/smf_slave_sva.sv
// concurrent checks on the slave front end ports
`timescale 1ns/100ps
module smf_slave_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o
);
  logic [5:0] bits_q;
  logic [7:0] op_q;
  wire        bad = !(op_q inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0B,
                                   8'h02, 8'hB9, 8'h9F});
  wire        mute = op_q inside {8'h06, 8'h04, 8'h01, 8'h02, 8'hB9};
  // cleared by deselect like the front end, so no reset of its own
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bits_q <= '0;
      op_q <= '0;
    end else begin
      bits_q <= bits_q + 6'(bits_q != 6'h3F);
      if (bits_q < 6'h08) op_q <= {op_q[6:0], si_i};
    end
  end
  a_desel_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_n_i |-> !so_oe_o) else $error("oe while deselected");
  a_out_edge: assert property (@(posedge clk_i) disable iff (cs_n_i)
    so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !sck_i) else $error("so moved");
  a_op_quiet: assert property (@(posedge sck_i) disable iff (cs_n_i)
    bits_q < 6'h08 |-> !so_oe_o) else $error("oe in opcode");
  a_addr_quiet: assert property (@(posedge sck_i) disable iff (cs_n_i)
    bits_q < 6'h18 && op_q == 8'h03 |-> !so_oe_o) else $error("oe in address");
  a_bad_mute: assert property (@(posedge sck_i) disable iff (cs_n_i)
    bits_q >= 6'h08 && (bad || mute) |-> !so_oe_o) else $error("oe not allowed");
  a_stat_on: assert property (@(posedge sck_i) disable iff (cs_n_i)
    bits_q == 6'h08 && op_q == 8'h05 |-> so_oe_o) else $error("no status out");
  a_read_on: assert property (@(posedge sck_i) disable iff (cs_n_i)
    bits_q == 6'h18 && op_q == 8'h03 |-> so_oe_o ##1 so_oe_o) else $error("no read out");
  a_fast_on: assert property (@(posedge sck_i) disable iff (cs_n_i)
    bits_q == 6'h20 && op_q == 8'h0B |-> so_oe_o) else $error("no fast out");
  c_read: cover property (@(posedge sck_i) bits_q == 6'h18 && op_q == 8'h03);
  c_stat: cover property (@(posedge sck_i) bits_q == 6'h08 && op_q == 8'h05);
  c_bad: cover property (@(posedge sck_i) bits_q == 6'h10 && bad);
endmodule : smf_slave_sva
bind smf_slave smf_slave_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_i),
  .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o));

// ===== test/test_spi_memory_slave_front.sv
// self-checking bench for the serial memory slave front end
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t mismatch", $time); end end
module test_spi_memory_slave_front;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wp_n_i = 1'b1;
  logic        sck, cs_n, si, so, so_oe, wel;
  logic [55:0] r;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          oe_rises = 0;
  always #2.5 clk_i = ~clk_i;
  always @(posedge so_oe) oe_rises++;
  smf_slave DUT (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .wel_o(wel));
  smf_master u_m (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));
  task automatic close_out;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic t_status;
    u_m.xfer(1'b0, {8'h05, 48'h0}, 16, r);
    `CHK(r[7:0], 8'h00)
    u_m.xfer(1'b1, {8'h06, 48'h0}, 8, r);
    u_m.xfer(1'b1, {8'h05, 48'h0}, 16, r);
    `CHK(r[7:0], 8'h02)
    repeat (8) @(negedge clk_i);
    `CHK(wel, 1'b1)
    $display("status test done");
  endtask : t_status
  task automatic t_mem;
    // top address bit sent set on purpose, it must be ignored
    u_m.xfer(1'b0, {8'h02, 16'hFFFE, 16'hA53C, 16'h0}, 40, r);
    u_m.xfer(1'b0, {8'h03, 16'h7FFE, 32'h0}, 40, r);
    `CHK(r[15:0], 16'hA53C)
    u_m.xfer(1'b1, {8'h0B, 16'h7FFF, 32'h0}, 40, r);
    `CHK(r[7:0], 8'h3C)
    repeat (8) @(negedge clk_i);
    `CHK(wel, 1'b0)
    $display("memory test done");
  endtask : t_mem
  task automatic t_bad;
    int k;
    k = oe_rises;
    u_m.xfer(1'b0, {8'hC3, 8'h05, 40'h0}, 24, r);
    `CHK(oe_rises, k)
    u_m.xfer(1'b0, {8'h05, 48'h0}, 16, r);
    `CHK(r[7:0], 8'h00)
    `CHK(so_oe, 1'b0)
    $display("invalid opcode test done");
  endtask : t_bad
  initial begin
    repeat (2) @(negedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    t_status;
    t_mem;
    t_bad;
    close_out;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end
endmodule : test_spi_memory_slave_front
